// [afc_chk.sv]
// afc_chk: bus answer and fan duty assertions on the afc_top ports
// assumes one clock domain and an active high reset
`timescale 1ns/100ps
`default_nettype none
module afc_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [7:0]  temp_remote1,
  input wire logic [7:0]  temp_local,
  input wire logic [7:0]  temp_remote2,
  input wire logic [7:0]  fan_duty0,
  input wire logic [7:0]  fan_duty1,
  input wire logic [7:0]  fan_duty2,
  input wire logic        critical_override
);
  // ========
  // helpers: completed write and all temperatures
  logic        wr;
  logic [23:0] tv;
  assign wr = psel && penable && pready && pwrite;
  assign tv = {temp_remote1, temp_local, temp_remote2};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // first access cycle, then an answer of exactly one cycle
  sequence s_acc; psel && penable && !$past(penable); endsequence
  sequence s_ans; pready ##1 !pready; endsequence
  // ========
  // assertions
  chk_acc_two: assert property (s_acc |=> s_ans)
    else $error("access phase not two cycles");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error flag outside answer");
  chk_wr_zero: assert property (wr |-> prdata == 32'h00000000)
    else $error("read data not zero on write");
  chk_rd_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h00000000)
    else $error("read data not zero on error");
  chk_ovr_full: assert property (
    critical_override |-> (fan_duty0 & fan_duty1 & fan_duty2) == 8'hFF)
    else $error("override without full duty");
  // latch state only moves when a temperature or a register moves
  chk_ovr_hold: assert property (
    critical_override && $stable(tv) && !$past(wr) |=> critical_override)
    else $error("override dropped with steady input");
  chk_duty_hold: assert property (
    !$past(rst) && $stable(tv) && !$past(wr) |=> $stable({fan_duty0, fan_duty1, fan_duty2}))
    else $error("duty moved with steady input");
endmodule // afc_chk
bind afc_top afc_chk afc_chk_i (.ref_clk, .rst, .psel, .penable, .pwrite, .pready, .prdata,
  .pslverr, .temp_remote1, .temp_local, .temp_remote2, .fan_duty0, .fan_duty1, .fan_duty2,
  .critical_override);
`default_nettype wire

// [afc_pkg.sv]
// afc_pkg: register map, reset values and slope table for the automatic
// fan duty block; shared by the top and the per-channel ramp.
// assumes 8-bit temperature codes in 1 degree steps, compared unsigned.
package afc_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned NCH    = 3;
  localparam int unsigned AW     = 12;
  localparam int unsigned DW     = 32;
  localparam int unsigned SLP_FB = 4;   // fraction bits of slope table

  // ==========================================================================
  // register indices (byte address = 4 * index)
  localparam logic [7:0] IDX_R1_SLOPE = 8'h5F;
  localparam logic [7:0] IDX_LC_SLOPE = 8'h60;
  localparam logic [7:0] IDX_R2_SLOPE = 8'h61;
  localparam logic [7:0] IDX_R1_CRIT  = 8'h6A;
  localparam logic [7:0] IDX_LC_CRIT  = 8'h6B;
  localparam logic [7:0] IDX_R2_CRIT  = 8'h6C;
  localparam logic [7:0] IDX_HYST_A   = 8'h6D;
  localparam logic [7:0] IDX_HYST_B   = 8'h6E;
  localparam logic [7:0] IDX_START0   = 8'h67;
  localparam logic [7:0] IDX_FLOOR0   = 8'h64;
  localparam logic [7:0] IDX_CEIL0    = 8'h38;
  localparam logic [7:0] IDX_STATUS   = 8'h70;

  // ==========================================================================
  // field positions
  localparam int unsigned SLOPE_LSB = 4;
  localparam int unsigned HYST_HI   = 4;
  localparam int unsigned ST_OVR    = 3;

  // ==========================================================================
  // reset values and the full duty code
  localparam logic [7:0] RST_SLOPE = 8'hC0;
  localparam logic [7:0] RST_CRIT  = 8'hA4;
  localparam logic [7:0] RST_HYSTA = 8'h44;
  localparam logic [7:0] RST_HYSTB = 8'h40;
  localparam logic [7:0] RST_START = 8'h9A;
  localparam logic [7:0] RST_FLOOR = 8'h80;
  localparam logic [7:0] RST_CEIL  = 8'hFF;
  localparam logic [7:0] FULL_DUTY = 8'hFF;

  // ==========================================================================
  // duty codes per degree, x16: 170 / span for the sixteen span codes
  localparam logic [15:0][10:0] SLOPE_TAB = {
    11'd34,   11'd51,   11'd68,  11'd85,  11'd102, 11'd136, 11'd170, 11'd204,
    11'd272,  11'd340,  11'd408, 11'd544, 11'd680, 11'd816, 11'd1088, 11'd1360};

  // strictly above a threshold
  function automatic logic above(input logic [7:0] t, input logic [7:0] lim);
    return t > lim;
  endfunction

  // strictly below lim - hyst, with no wrap when hyst exceeds lim
  function automatic logic below_rel(input logic [7:0] t, input logic [7:0] lim,
                                     input logic [3:0] hy);
    return ({1'b0, t} + {5'h00, hy}) < {1'b0, lim};
  endfunction

endpackage

// [afc_ramp.sv]
// afc_ramp: combinational duty for one channel from temperature, start
// temperature, slope code, floor and ceiling duty.
// assumes the caller registers the result and owns the on/off state.
`timescale 1ns/100ps
`default_nettype none

module afc_ramp (
  input  wire logic [7:0] temp,
  input  wire logic [7:0] start_temp,
  input  wire logic [3:0] slope_code,
  input  wire logic [7:0] floor_duty,
  input  wire logic [7:0] ceiling_duty,
  input  wire logic       fan_on,
  output logic      [7:0] duty
);

  logic [7:0]  delta;
  logic [18:0] prod;
  logic [15:0] sum;
  logic [7:0]  ramp;

  // ==========================================================================
  // linear ramp from the floor, fixed slope whatever the floor is
  always_comb
  begin
    delta = (temp > start_temp) ? 8'(temp - start_temp) : 8'h00;
    prod  = 19'(delta) * 19'(afc_pkg::SLOPE_TAB[slope_code]);
    sum   = 16'(floor_duty) + 16'(prod >> afc_pkg::SLP_FB);
    ramp  = (sum > 16'(afc_pkg::FULL_DUTY)) ? afc_pkg::FULL_DUTY : sum[7:0];
    if (!fan_on)
      duty = 8'h00;
    else if (ramp > ceiling_duty)
      duty = ceiling_duty;
    else
      duty = ramp;
  end

endmodule // afc_ramp

`default_nettype wire

// [afc_temp_src.sv]
// afc_temp_src: stand-in for the temperature measurement channels
// assumes the bench sets the sensed values; one conversion per clock
`timescale 1ns/100ps
`default_nettype none
module afc_temp_src (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [7:0] set0,
  input  wire logic [7:0] set1,
  input  wire logic [7:0] set2,
  output logic      [7:0] temp_remote1,
  output logic      [7:0] temp_local,
  output logic      [7:0] temp_remote2
);
  // a result lands one edge after the sensed value, like a real converter
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      {temp_remote1, temp_local, temp_remote2} <= 24'h000000;
    else
      {temp_remote1, temp_local, temp_remote2} <= {set0, set1, set2};
  end
endmodule // afc_temp_src
`default_nettype wire

// [afc_top.sv]
// afc_top: automatic fan duty with per-channel slope and a critical
// override that drives every fan to full duty, behind an APB slave.
// assumes temperatures come from same-clock measurement logic; channel n
// drives fan output n (no mux here).
//
// Operation
// - above its start temperature a channel's duty rises linearly until full duty.
// - each channel has a 4-bit span code in bits 7:4, 0000 = 2 deg to 1111 = 80 deg, reset 1100.
// - span codes live at 0x5F remote 1, 0x60 local, 0x61 remote 2.
// - full-speed temperature is start + (255 - floor) * span / 170.
// - duty code 255 means 100 percent and is the ramp's top.
// - raising the floor keeps the same slope, so full duty comes earlier.
// - any channel above its critical limit drives every fan at full duty.
// - full duty holds until that channel drops below limit minus hysteresis.
// - the critical override cannot be masked by any fan setting.
// - critical limits sit at 0x6A, 0x6B, 0x6C and reset to 0xA4.
// - hysteresis: 0x6D bits 7:4 remote 1, 3:0 local; 0x6E bits 7:4 remote 2; default 4.
// - each hysteresis field is four bits of whole degrees up to 15.
// - a fan switches on at floor duty above start and off below start minus hysteresis.
// - the ceiling duty limits the ramp but not the critical override.
`timescale 1ns/100ps
`default_nettype none

module afc_top (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [afc_pkg::AW-1:0] paddr,
  input  wire logic [afc_pkg::DW-1:0] pwdata,
  input  wire logic [3:0]             pstrb,
  output logic                        pready,
  output logic      [afc_pkg::DW-1:0] prdata,
  output logic                        pslverr,
  input  wire logic [7:0]             temp_remote1,
  input  wire logic [7:0]             temp_local,
  input  wire logic [7:0]             temp_remote2,
  output logic      [7:0]             fan_duty0,
  output logic      [7:0]             fan_duty1,
  output logic      [7:0]             fan_duty2,
  output logic                        critical_override
);

  typedef struct packed {
    logic [afc_pkg::NCH-1:0][7:0] slope;
    logic [afc_pkg::NCH-1:0][7:0] crit;
    logic [7:0]                   hyst_a;
    logic [3:0]                   hyst_b;
    logic [afc_pkg::NCH-1:0][7:0] start;
    logic [afc_pkg::NCH-1:0][7:0] floor_d;
    logic [afc_pkg::NCH-1:0][7:0] ceil_d;
    logic [afc_pkg::NCH-1:0]      fan_on;
    logic [afc_pkg::NCH-1:0]      crit_lat;
    logic [afc_pkg::NCH-1:0][7:0] duty;
    logic                         ovr;
    logic                         ready;
    logic [afc_pkg::DW-1:0]       rdata;
    logic                         err;
  } afc_state_s;

  afc_state_s st_q;
  afc_state_s st_d;

  logic [afc_pkg::NCH-1:0][7:0] temp;
  logic [afc_pkg::NCH-1:0][3:0] hyst;
  logic [afc_pkg::NCH-1:0][7:0] ramp_duty;
  logic [afc_pkg::NCH-1:0]      fan_nx;
  logic [7:0]                   idx;
  logic                         addr_ok;
  logic                         wr_commit;

  // ==========================================================================
  // channel views
  assign temp[0] = temp_remote1;
  assign temp[1] = temp_local;
  assign temp[2] = temp_remote2;
  // hysteresis nibbles shared by fan on/off and critical release
  assign hyst[0] = st_q.hyst_a[7:afc_pkg::HYST_HI];
  assign hyst[1] = st_q.hyst_a[afc_pkg::HYST_HI-1:0];
  assign hyst[2] = st_q.hyst_b;

  // ==========================================================================
  // per-channel ramp
  for (genvar g = 0; g < afc_pkg::NCH; g++)
  begin : g_ch
    // on/off settles before the ramp reads it, so a fan starts at floor duty
    // in the same edge that sees it cross the start temperature
    assign fan_nx[g] = afc_pkg::above(temp[g], st_q.start[g]) ? 1'b1 :
                       afc_pkg::below_rel(temp[g], st_q.start[g], hyst[g]) ? 1'b0 :
                       st_q.fan_on[g];
    afc_ramp u_ramp (
      .temp         (temp[g]),
      .start_temp   (st_q.start[g]),
      .slope_code   (st_q.slope[g][7:afc_pkg::SLOPE_LSB]),
      .floor_duty   (st_q.floor_d[g]),
      .ceiling_duty (st_q.ceil_d[g]),
      .fan_on       (fan_nx[g]),
      .duty         (ramp_duty[g])
    );
  end

  // ==========================================================================
  // APB decode: word aligned, index in paddr[9:2], one wait state
  assign idx       = paddr[9:2];
  assign addr_ok   = (paddr[1:0] == 2'b00) && (paddr[afc_pkg::AW-1:10] == '0);
  assign wr_commit = psel && penable && pwrite && st_q.ready;

  // read mux; unmapped answers zero with error
  function automatic logic [8:0] rd_reg(input afc_state_s s, input logic [7:0] i);
    logic [8:0] r;
    r = {1'b1, 8'h00};
    unique case (i)
      afc_pkg::IDX_R1_SLOPE: r = {1'b0, s.slope[0]};
      afc_pkg::IDX_LC_SLOPE: r = {1'b0, s.slope[1]};
      afc_pkg::IDX_R2_SLOPE: r = {1'b0, s.slope[2]};
      afc_pkg::IDX_R1_CRIT:  r = {1'b0, s.crit[0]};
      afc_pkg::IDX_LC_CRIT:  r = {1'b0, s.crit[1]};
      afc_pkg::IDX_R2_CRIT:  r = {1'b0, s.crit[2]};
      afc_pkg::IDX_HYST_A:   r = {1'b0, s.hyst_a};
      afc_pkg::IDX_HYST_B:   r = {1'b0, s.hyst_b, 4'h0};
      afc_pkg::IDX_STATUS:   r = {1'b0, 4'h0, s.ovr, s.crit_lat};
      default:
      begin
        for (int k = 0; k < afc_pkg::NCH; k++)
        begin
          if (i == afc_pkg::IDX_START0 + 8'(k)) r = {1'b0, s.start[k]};
          if (i == afc_pkg::IDX_FLOOR0 + 8'(k)) r = {1'b0, s.floor_d[k]};
          if (i == afc_pkg::IDX_CEIL0 + 8'(k))  r = {1'b0, s.ceil_d[k]};
        end
      end
    endcase
    return r;
  endfunction

  // ==========================================================================
  // next state
  always_comb
  begin
    logic [8:0] rd;
    logic       any_lat;
    rd      = rd_reg(st_q, idx);
    any_lat = 1'b0;
    st_d    = st_q;

    // bus answer: ready rises one cycle into access, drops after the edge
    st_d.ready = psel && penable && !st_q.ready;
    // data and error stand for the answer cycle only; a stale error
    // must not outlive its own transfer
    st_d.rdata = '0;
    st_d.err   = 1'b0;
    if (psel && penable && !st_q.ready)
    begin
      st_d.rdata = pwrite ? '0 : {24'h000000, rd[7:0]};
      st_d.err   = !addr_ok || rd[8] || (pwrite && idx == afc_pkg::IDX_STATUS);
    end

    // register writes, low byte lane only
    if (wr_commit && addr_ok && pstrb[0])
    begin
      unique case (idx)
        afc_pkg::IDX_R1_SLOPE: st_d.slope[0] = pwdata[7:0];
        afc_pkg::IDX_LC_SLOPE: st_d.slope[1] = pwdata[7:0];
        afc_pkg::IDX_R2_SLOPE: st_d.slope[2] = pwdata[7:0];
        afc_pkg::IDX_R1_CRIT:  st_d.crit[0]  = pwdata[7:0];
        afc_pkg::IDX_LC_CRIT:  st_d.crit[1]  = pwdata[7:0];
        afc_pkg::IDX_R2_CRIT:  st_d.crit[2]  = pwdata[7:0];
        afc_pkg::IDX_HYST_A:   st_d.hyst_a   = pwdata[7:0];
        afc_pkg::IDX_HYST_B:   st_d.hyst_b   = pwdata[7:afc_pkg::HYST_HI];
        default:
        begin
          for (int k = 0; k < afc_pkg::NCH; k++)
          begin
            if (idx == afc_pkg::IDX_START0 + 8'(k)) st_d.start[k]   = pwdata[7:0];
            if (idx == afc_pkg::IDX_FLOOR0 + 8'(k)) st_d.floor_d[k] = pwdata[7:0];
            if (idx == afc_pkg::IDX_CEIL0 + 8'(k))  st_d.ceil_d[k]  = pwdata[7:0];
          end
        end
      endcase
    end

    // per-channel on/off and critical latches; zero hysteresis chatters
    for (int k = 0; k < afc_pkg::NCH; k++)
    begin
      st_d.fan_on[k] = fan_nx[k];
      if (afc_pkg::above(temp[k], st_q.crit[k]))
        st_d.crit_lat[k] = 1'b1;
      else if (afc_pkg::below_rel(temp[k], st_q.crit[k], hyst[k]))
        st_d.crit_lat[k] = 1'b0;
      any_lat = any_lat || st_d.crit_lat[k];
    end
    st_d.ovr = any_lat;

    // override bypasses ramp, floor and ceiling alike
    for (int k = 0; k < afc_pkg::NCH; k++)
      st_d.duty[k] = any_lat ? afc_pkg::FULL_DUTY : ramp_duty[k];
  end

  // ==========================================================================
  // state register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q          <= '0;
      st_q.slope    <= {afc_pkg::NCH{afc_pkg::RST_SLOPE}};
      st_q.crit     <= {afc_pkg::NCH{afc_pkg::RST_CRIT}};
      st_q.hyst_a   <= afc_pkg::RST_HYSTA;
      st_q.hyst_b   <= afc_pkg::RST_HYSTB[7:afc_pkg::HYST_HI];
      st_q.start    <= {afc_pkg::NCH{afc_pkg::RST_START}};
      st_q.floor_d  <= {afc_pkg::NCH{afc_pkg::RST_FLOOR}};
      st_q.ceil_d   <= {afc_pkg::NCH{afc_pkg::RST_CEIL}};
    end
    else
      st_q <= st_d;
  end

  // ==========================================================================
  // outputs straight from the state register
  assign pready            = st_q.ready;
  assign prdata            = st_q.rdata;
  assign pslverr           = st_q.err;
  assign fan_duty0         = st_q.duty[0];
  assign fan_duty1         = st_q.duty[1];
  assign fan_duty2         = st_q.duty[2];
  assign critical_override = st_q.ovr;

endmodule // afc_top

`default_nettype wire

// [tb_top.sv]
// tb_top: self-checking bench for afc_top with an APB master
// assumes afc_pkg, afc_temp_src and afc_chk are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, critical_override;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, strb = 4'hF;
  logic [7:0]  set0, set1, set2, temp_remote1, temp_local, temp_remote2;
  logic [7:0]  fan_duty0, fan_duty1, fan_duty2;
  int          err_total = 0, cmp_count = 0;
  int          slp [16] = '{1360,1088,816,680,544,408,340,272,204,170,136,102,85,68,51,34};
  logic [15:0] rdef [8] = '{16'h5FC0,16'h60C0,16'h61C0,16'h6AA4,16'h6BA4,16'h6CA4,16'h6D44,16'h6E40};
  // temps in, duties out, override expected low (defaults: start 154, floor 128)
  logic [47:0] rows [4] = '{48'h646464000000, 48'h9BA09A859F00, 48'h9896A48080B5, 48'h95A0A4009FB5};
  afc_top afc_top_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .temp_remote1, .temp_local, .temp_remote2, .fan_duty0, .fan_duty1,
    .fan_duty2, .critical_override);
  afc_temp_src afc_temp_src_i (.ref_clk, .rst, .set0, .set1, .set2, .temp_remote1, .temp_local,
    .temp_remote2);
  // ========
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one APB transfer; the request holds until pready is sampled high at an
  // edge, the answer is taken at that edge and only then released
  task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d,
                     input logic [7:0] e, input logic ee);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= {24'h000000, d};
    pstrb <= strb;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1);
    // the slave answers in the second access cycle
    chk("access cycles", 32'd2, 32'(n));
    if (!w) chk("prdata", {24'h000000, e}, prdata);
    chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // sensor plus duty latency is two edges
  task automatic tchk(input logic [23:0] t, input logic [23:0] e, input logic o);
    {set0, set1, set2} <= t;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("duty", {8'h00, e}, {8'h00, fan_duty0, fan_duty1, fan_duty2});
    chk("override", {31'h0, o}, {31'h0, critical_override});
    @(posedge ref_clk);
  endtask
  // ========
  // clock and watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  begin
    #20000;
    err_total++;
    $display("ERROR watchdog exp finish got timeout");
    stop_test();
  end
  // ========
  // main sequence
  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 12'h000, 32'h0, 4'hF};
    {set0, set1, set2} = 24'h000000;
    repeat (3) @(posedge ref_clk);
    chk("in reset", 32'h0, {fan_duty0, fan_duty1, fan_duty2, critical_override, pready});
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 8; i++) apb(1'b0, rdef[i][15:8], 8'h00, rdef[i][7:0], 1'b0);
    apb(1'b0, 8'h00, 8'h00, 8'h00, 1'b1);
    $display("register defaults done");
    for (int i = 0; i < 4; i++) tchk(rows[i][47:24], rows[i][23:0], 1'b0);
    $display("ramp rows done");
    tchk(24'hA56464, 24'hFFFFFF, 1'b1);
    tchk(24'hA16464, 24'hFFFFFF, 1'b1);
    tchk(24'h9F6464, 24'h9A0000, 1'b0);
    tchk(24'hA564A5, 24'hFFFFFF, 1'b1);
    tchk(24'h6464A5, 24'hFFFFFF, 1'b1);
    apb(1'b0, afc_pkg::IDX_STATUS, 8'h00, 8'h0C, 1'b0);
    apb(1'b1, afc_pkg::IDX_STATUS, 8'h00, 8'h00, 1'b1);
    tchk(24'h646464, 24'h000000, 1'b0);
    apb(1'b1, afc_pkg::IDX_CEIL0, 8'h90, 8'h00, 1'b0);
    tchk(24'hA06464, 24'h900000, 1'b0);
    tchk(24'hA56464, 24'hFFFFFF, 1'b1);
    $display("override done");
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, 8'h60, {c[3:0], 4'h0}, 8'h00, 1'b0);
      tchk(24'h649B64, {8'h00, 8'h80 + 8'(slp[c] / 16), 8'h00}, 1'b0);
    end
    apb(1'b1, 8'h6B, 8'hFF, 8'h00, 1'b0);
    tchk(24'h64D564, 24'h00FD00, 1'b0);
    tchk(24'h64D664, 24'h00FF00, 1'b0);
    strb = 4'hE;
    apb(1'b1, 8'h65, 8'hC0, 8'h00, 1'b0);
    tchk(24'h64B464, 24'h00B700, 1'b0);
    strb = 4'hF;
    apb(1'b1, 8'h65, 8'hC0, 8'h00, 1'b0);
    tchk(24'h64B464, 24'h00F700, 1'b0);
    // only non-zero hysteresis is ever programmed
    apb(1'b1, afc_pkg::IDX_HYST_B, 8'h3F, 8'h00, 1'b0);
    apb(1'b0, afc_pkg::IDX_HYST_B, 8'h00, 8'h30, 1'b0);
    $display("slope done");
    rst <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("mid reset", 32'h0, {fan_duty0, fan_duty1, fan_duty2, critical_override});
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, afc_pkg::IDX_CEIL0, 8'h00, 8'hFF, 1'b0);
    apb(1'b0, 8'h6B, 8'h00, 8'hA4, 1'b0);
    apb(1'b0, afc_pkg::IDX_HYST_B, 8'h00, 8'h40, 1'b0);
    $display("second reset done");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
